// >>> rtl/alu_adder.v
// eight-bit adder with carry, half carry and overflow
`timescale 1ns/1ps
`default_nettype none
module alu_adder (
	input  wire [7:0] a_in,
	input  wire [7:0] b_in,
	input  wire       sub_in,
	input  wire       cin_in,
	output wire [7:0] sum_out,
	output wire       carry_out,
	output wire       half_out,
	output wire       ovf_out
);
	wire [7:0] b_eff;
	wire [8:0] full;
	wire [4:0] low;
	wire       cin_eff;
	// ----------------------------------------
	// subtract as add of complement
	// ----------------------------------------
	assign b_eff     = sub_in ? ~b_in : b_in;
	assign cin_eff   = sub_in ? ~cin_in : cin_in;
	assign full      = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, cin_eff};
	assign low       = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
	assign sum_out   = full[7:0];
	assign carry_out = sub_in ? ~full[8] : full[8];
	assign half_out  = sub_in ? ~low[4] : low[4];
	assign ovf_out   = (a_in[7] == b_eff[7]) && (full[7] != a_in[7]);
endmodule // alu_adder
`default_nettype wire

// >>> rtl/alu_defs.vh
// constants of the arithmetic and logic datapath
`ifndef ALU_DEFS_VH
`define ALU_DEFS_VH
// ----------------------------------------
// operation codes
// ----------------------------------------
`define OP_NONE        5'h00
`define OP_ADD         5'h01
`define OP_ADD_CARRY   5'h02
`define OP_WORD_PLUS   5'h03
`define OP_SUB         5'h04
`define OP_DIFF_IMM    5'h05
`define OP_DIFF_BORROW 5'h06
`define OP_DIFF_IMM_BR 5'h07
`define OP_WORD_MINUS  5'h08
`define OP_AND         5'h09
`define OP_CONJ_IMM    5'h0A
`define OP_OR          5'h0B
`define OP_DISJ_IMM    5'h0C
`define OP_XOR         5'h0D
`define OP_INVERT      5'h0E
`define OP_ARITH_INV   5'h0F
`define OP_IO_SET      5'h10
`define OP_IO_CLEAR    5'h11
`define OP_SKIP_HIGH   5'h12
`define OP_SKIP_LOW    5'h13
// ----------------------------------------
// flag positions and reset values
// ----------------------------------------
`define FLAG_C         0
`define FLAG_Z         1
`define FLAG_N         2
`define FLAG_V         3
`define FLAG_S         4
`define FLAG_H         5
`define FLAGS_RESET    6'h00
// ----------------------------------------
// io bit space and constants
// ----------------------------------------
`define IO_BIT_MAX     6'h1F
`define ALL_ONES       8'hFF
`define ALL_ZEROS      8'h00
`define WORD_CYCLES    2'h2
`endif

// >>> rtl/arith_logic_datapath.v
// arithmetic and logic datapath of the small core
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.vh"
module arith_logic_datapath #(
	parameter WIDTH = 8
) (
	input  wire             mclk_in,
	input  wire             rstn_in,
	input  wire             start_in,
	input  wire [4:0]       op_in,
	input  wire [WIDTH-1:0] dst_in,
	input  wire [WIDTH-1:0] src_reg_in,
	input  wire [WIDTH-1:0] dst_high_in,
	input  wire [WIDTH-1:0] imm_in,
	input  wire [5:0]       io_addr_in,
	input  wire [2:0]       io_bit_in,
	input  wire [WIDTH-1:0] io_data_in,
	output wire             busy_out,
	output reg              done_out,
	output reg  [WIDTH-1:0] result_out,
	output reg  [WIDTH-1:0] result_high_out,
	output reg              result_we_out,
	output reg              result_high_we_out,
	output reg  [WIDTH-1:0] io_wdata_out,
	output reg  [WIDTH-1:0] io_wmask_out,
	output reg              io_we_out,
	output reg              skip_out,
	output reg              io_range_err_out,
	output wire [5:0]       flags_out
);
	reg  [5:0]       flags;
	reg  [5:0]       next_flags;
	reg              word_phase;
	reg  [WIDTH-1:0] word_high;
	reg              word_sub;
	reg              word_carry;
	reg  [WIDTH-1:0] add_a;
	reg  [WIDTH-1:0] add_b;
	reg              add_sub;
	reg              add_cin;
	wire [WIDTH-1:0] add_sum;
	wire             add_c;
	wire             add_h;
	wire             add_v;
	reg  [WIDTH-1:0] logic_res;
	wire [WIDTH-1:0] bit_mask;
	wire             io_ok;
	wire [WIDTH-1:0] res_word_hi;
	genvar           g;
	assign flags_out = flags;
	assign busy_out  = word_phase;
	assign io_ok     = (io_addr_in <= `IO_BIT_MAX);
	// ----------------------------------------
	// bit mask, one bit per lane
	// ----------------------------------------
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_mask
			assign bit_mask[g] = ({29'h00000000, io_bit_in} == g);
		end
	endgenerate
	// ----------------------------------------
	// shared adder
	// ----------------------------------------
	always @* begin
		add_a   = dst_in;
		add_b   = src_reg_in;
		add_sub = 1'b0;
		add_cin = 1'b0;
		if (word_phase) begin
			add_a   = word_high;
			add_b   = `ALL_ZEROS;
			add_sub = word_sub;
			add_cin = word_carry; // carry into high byte
		end else begin
			case (op_in)
				`OP_ADD: begin
					add_cin = 1'b0;
				end
				`OP_ADD_CARRY: begin
					add_cin = flags[`FLAG_C];
				end
				`OP_WORD_PLUS: begin
					add_b = imm_in;
				end
				`OP_SUB: begin
					add_sub = 1'b1;
				end
				`OP_DIFF_IMM: begin
					add_sub = 1'b1;
					add_b   = imm_in;
				end
				`OP_DIFF_BORROW: begin
					add_sub = 1'b1;
					add_cin = flags[`FLAG_C];
				end
				`OP_DIFF_IMM_BR: begin
					add_sub = 1'b1;
					add_b   = imm_in;
					add_cin = flags[`FLAG_C];
				end
				`OP_WORD_MINUS: begin
					add_sub = 1'b1;
					add_b   = imm_in;
				end
				`OP_ARITH_INV: begin
					add_sub = 1'b1;
					add_a   = `ALL_ZEROS;
					add_b   = dst_in;
				end
				default: begin
					add_cin = 1'b0;
				end
			endcase
		end
	end
	alu_adder u_adder (
		.a_in      (add_a),
		.b_in      (add_b),
		.sub_in    (add_sub),
		.cin_in    (add_cin),
		.sum_out   (add_sum),
		.carry_out (add_c),
		.half_out  (add_h),
		.ovf_out   (add_v)
	);
	// ----------------------------------------
	// logic unit
	// ----------------------------------------
	always @* begin
		case (op_in)
			`OP_AND:      logic_res = dst_in & src_reg_in;
			`OP_CONJ_IMM: logic_res = dst_in & imm_in;
			`OP_OR:       logic_res = dst_in | src_reg_in;
			`OP_DISJ_IMM: logic_res = dst_in | imm_in;
			`OP_XOR:      logic_res = dst_in ^ src_reg_in;
			`OP_INVERT:   logic_res = `ALL_ONES - dst_in;
			default:      logic_res = `ALL_ZEROS;
		endcase
	end
	assign res_word_hi = add_sum;
	// ----------------------------------------
	// next flags
	// ----------------------------------------
	always @* begin
		next_flags = flags;
		if (word_phase) begin
			// word flags from the full 16-bit result
			next_flags[`FLAG_Z] = (res_word_hi == `ALL_ZEROS) && (result_out == `ALL_ZEROS);
			next_flags[`FLAG_N] = res_word_hi[WIDTH-1];
			next_flags[`FLAG_V] = word_sub ? (word_high[WIDTH-1] & ~res_word_hi[WIDTH-1])
			                               : (~word_high[WIDTH-1] & res_word_hi[WIDTH-1]);
			next_flags[`FLAG_C] = add_c;
			next_flags[`FLAG_S] = next_flags[`FLAG_N] ^ next_flags[`FLAG_V];
		end else if (start_in) begin
			case (op_in)
				`OP_ADD, `OP_ADD_CARRY, `OP_SUB, `OP_DIFF_IMM, `OP_DIFF_BORROW,
				`OP_DIFF_IMM_BR, `OP_ARITH_INV: begin
					next_flags[`FLAG_Z] = (add_sum == `ALL_ZEROS);
					next_flags[`FLAG_C] = add_c;
					next_flags[`FLAG_N] = add_sum[WIDTH-1];
					next_flags[`FLAG_V] = add_v;
					next_flags[`FLAG_H] = add_h;
				end
				`OP_AND, `OP_CONJ_IMM, `OP_OR, `OP_DISJ_IMM, `OP_XOR: begin
					next_flags[`FLAG_Z] = (logic_res == `ALL_ZEROS);
					next_flags[`FLAG_N] = logic_res[WIDTH-1];
					next_flags[`FLAG_V] = 1'b0;
				end
				`OP_INVERT: begin
					next_flags[`FLAG_Z] = (logic_res == `ALL_ZEROS);
					next_flags[`FLAG_C] = 1'b1;
					next_flags[`FLAG_N] = logic_res[WIDTH-1];
					next_flags[`FLAG_V] = 1'b0;
				end
				`OP_IO_SET, `OP_IO_CLEAR, `OP_SKIP_HIGH, `OP_SKIP_LOW: begin
					next_flags = flags; // io bit ops leave every flag
				end
				default: begin
					next_flags = flags;
				end
			endcase
		end
	end
	// ----------------------------------------
	// sequencing and outputs
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			flags              <= `FLAGS_RESET;
			word_phase         <= 1'b0;
			word_high          <= `ALL_ZEROS;
			word_sub           <= 1'b0;
			word_carry         <= 1'b0;
			done_out           <= 1'b0;
			result_out         <= `ALL_ZEROS;
			result_high_out    <= `ALL_ZEROS;
			result_we_out      <= 1'b0;
			result_high_we_out <= 1'b0;
			io_wdata_out       <= `ALL_ZEROS;
			io_wmask_out       <= `ALL_ZEROS;
			io_we_out          <= 1'b0;
			skip_out           <= 1'b0;
			io_range_err_out   <= 1'b0;
		end else begin
			flags              <= next_flags;
			done_out           <= 1'b0;
			result_we_out      <= 1'b0;
			result_high_we_out <= 1'b0;
			io_we_out          <= 1'b0;
			skip_out           <= 1'b0;
			io_range_err_out   <= 1'b0;
			if (word_phase) begin
				word_phase         <= 1'b0; // second clock of word op
				result_high_out    <= res_word_hi;
				result_high_we_out <= 1'b1;
				result_we_out      <= 1'b1;
				done_out           <= 1'b1;
			end else if (start_in) begin
				case (op_in)
					`OP_ADD, `OP_ADD_CARRY, `OP_SUB, `OP_DIFF_IMM, `OP_DIFF_BORROW,
					`OP_DIFF_IMM_BR, `OP_ARITH_INV: begin
						result_out    <= add_sum;
						result_we_out <= 1'b1;
						done_out      <= 1'b1;
					end
					`OP_WORD_PLUS, `OP_WORD_MINUS: begin
						result_out <= add_sum; // low byte held until phase two
						word_high  <= dst_high_in;
						word_sub   <= (op_in == `OP_WORD_MINUS);
						word_carry <= add_c;
						word_phase <= 1'b1;
					end
					`OP_AND, `OP_CONJ_IMM, `OP_OR, `OP_DISJ_IMM, `OP_XOR, `OP_INVERT: begin
						result_out    <= logic_res;
						result_we_out <= 1'b1;
						done_out      <= 1'b1;
					end
					`OP_IO_SET, `OP_IO_CLEAR: begin
						done_out <= 1'b1;
						if (io_ok) begin
							io_wmask_out <= bit_mask; // only the addressed bit
							io_wdata_out <= (op_in == `OP_IO_SET) ? bit_mask : `ALL_ZEROS;
							io_we_out    <= 1'b1;
						end else begin
							io_range_err_out <= 1'b1;
						end
					end
					`OP_SKIP_HIGH, `OP_SKIP_LOW: begin
						done_out <= 1'b1;
						if (io_ok) begin
							skip_out <= ((|(io_data_in & bit_mask)) == (op_in == `OP_SKIP_HIGH));
						end else begin
							io_range_err_out <= 1'b1;
						end
					end
					default: begin
						done_out <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule // arith_logic_datapath
`default_nettype wire

// >>> sim/alu_checker_asserts.sv
// port assertions of the datapath
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.vh"
module alu_checker (
	input wire       mclk_in, rstn_in, start_in, busy_out, done_out, result_we_out, result_high_we_out,
	input wire       io_we_out, skip_out, io_range_err_out,
	input wire [4:0] op_in,
	input wire [5:0] io_addr_in, flags_out,
	input wire [2:0] io_bit_in,
	input wire [7:0] io_data_in, io_wmask_out, result_out, result_high_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	wire take  = start_in && !busy_out;
	wire word  = op_in == `OP_WORD_PLUS || op_in == `OP_WORD_MINUS;
	wire io_ok = io_addr_in <= `IO_BIT_MAX;
	reg  sel_bit;
	always @(posedge mclk_in) sel_bit <= io_data_in[io_bit_in];
	sequence word_tail;
		busy_out && !done_out ##1 done_out && result_we_out && result_high_we_out;
	endsequence
	one_clk_done_a: assert property (take && op_in >= `OP_ADD && op_in <= `OP_ARITH_INV && !word
		|=> done_out && result_we_out && !busy_out) else $error("one clock op not done");
	word_two_clk_a: assert property (take && word |=> word_tail) else $error("word op timing");
	busy_once_a: assert property (busy_out |=> !busy_out) else $error("busy too long");
	io_range_a: assert property (take && (op_in == `OP_IO_SET || op_in == `OP_IO_CLEAR) && !io_ok
		|=> io_range_err_out && !io_we_out) else $error("io range not refused");
	io_one_bit_a: assert property (take && op_in == `OP_IO_SET && io_ok
		|=> io_we_out && io_wmask_out == 8'h01 << $past(io_bit_in)) else $error("io mask wrong");
	skip_bit_a: assert property (take && op_in == `OP_SKIP_HIGH && io_ok
		|=> skip_out == sel_bit) else $error("skip wrong");
	s_word_only_a: assert property ($changed(flags_out[`FLAG_S]) |-> result_high_we_out) else $error("S moved");
	word_flags_a: assert property (result_high_we_out |-> $stable(flags_out[`FLAG_H])
		&& flags_out[`FLAG_S] == (flags_out[`FLAG_N] ^ flags_out[`FLAG_V])) else $error("word flags");
	zero_neg_a: assert property (result_we_out && !result_high_we_out
		|-> flags_out[`FLAG_Z] == (result_out == 8'h00) && flags_out[`FLAG_N] == result_out[7]) else $error("Z N");
endmodule // alu_checker
bind arith_logic_datapath alu_checker u_chk (.*);
`default_nettype wire

// >>> sim/arith_logic_datapath_test.sv
// self-checking bench of the datapath
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.vh"
module arith_logic_datapath_test;
	logic       mclk_in = 0, rstn_in = 0, start_in = 0;
	logic [4:0] op_in = 0;
	logic [5:0] io_addr_in = 0, flags_out, ef = 0;
	logic [2:0] io_bit_in = 0;
	logic [7:0] dst_in = 0, src_reg_in = 0, dst_high_in = 0, imm_in = 0, io_data_in, result_out, result_high_out;
	logic [7:0] io_wdata_out, io_wmask_out;
	logic       busy_out, done_out, result_we_out, result_high_we_out, io_we_out, skip_out, io_range_err_out;
	int         err_count = 0, samples_checked = 0;
	always #50 mclk_in = ~mclk_in;
	arith_logic_datapath u_dut (.*);
	io_space_model u_io (.mclk_in(mclk_in), .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_out),
		.io_wmask_in(io_wmask_out), .io_we_in(io_we_out), .io_data_out(io_data_in));
	task automatic check(input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic run(input logic [4:0] o, input logic [7:0] d, b, h, input logic [5:0] a, input logic [2:0] n);
		int w;
		@(posedge mclk_in);
		op_in <= o;
		dst_in <= d;
		src_reg_in <= b;
		imm_in <= b;
		dst_high_in <= h;
		io_addr_in <= a;
		io_bit_in <= n;
		start_in <= 1'b1;
		@(posedge mclk_in);
		start_in <= 1'b0;
		#1;
		for (w = 0; w < 4 && done_out !== 1'b1; w++) begin
			@(posedge mclk_in);
			#1;
		end
		if (w == 4) begin
			err_count++;
			finish_test;
		end
	endtask
	// arithmetic, logic and word ops with expected flags
	task automatic op(input logic [4:0] o, input logic [7:0] d, b, h = 8'h00);
		logic [16:0] r;
		logic [4:0]  hc;
		logic        c, sub, lg, v;
		run(o, d, b, h, 6'h00, 3'h0);
		c = (o == `OP_ADD_CARRY || o == `OP_DIFF_BORROW || o == `OP_DIFF_IMM_BR) ? ef[0] : 1'b0;
		sub = (o >= `OP_SUB && o <= `OP_DIFF_IMM_BR) || o == `OP_ARITH_INV;
		lg = o >= `OP_AND && o <= `OP_INVERT;
		if (o == `OP_ARITH_INV) begin
			b = d;
			d = 8'h00;
		end
		if (o == `OP_WORD_PLUS || o == `OP_WORD_MINUS) begin
			r = (o == `OP_WORD_MINUS) ? {1'b0, h, d} - b : {1'b0, h, d} + b;
			v = (o == `OP_WORD_MINUS) ? h[7] & !r[15] : !h[7] & r[15];
			ef = {ef[5], r[15] ^ v, v, r[15], r[15:0] == 16'h0000, r[16]};
			check({result_high_out, result_out}, r[15:0]);
		end else begin
			case (o)
				`OP_AND, `OP_CONJ_IMM: r = {ef[0], d & b};
				`OP_OR, `OP_DISJ_IMM: r = {ef[0], d | b};
				`OP_XOR: r = {ef[0], d ^ b};
				`OP_INVERT: r = {1'b1, ~d};
				default: r = sub ? {1'b0, d} - b - c : {1'b0, d} + b + c;
			endcase
			hc = sub ? {1'b0, d[3:0]} - b[3:0] - c : {1'b0, d[3:0]} + b[3:0] + c;
			v = ((d[7] ^ b[7]) == sub) && (r[7] != d[7]) && !lg;
			ef = {lg ? ef[5] : hc[4], ef[4], v, r[7], r[7:0] == 8'h00, r[8]};
			check(result_out, r[7:0]);
		end
		check(flags_out, ef);
	endtask
	// io bit ops: skip and refusal pulses, then the stored value
	task automatic io(input logic [4:0] o, input logic [5:0] a, input logic [2:0] n, input logic sk, er, logic [7:0] v);
		run(o, 8'h00, 8'h00, 8'h00, a, n);
		check({skip_out, io_range_err_out}, {sk, er});
		check(flags_out, ef);
		@(posedge mclk_in);
		#1;
		check(io_data_in, v);
	endtask
	initial begin
		repeat (5) @(posedge mclk_in);
		rstn_in <= 1'b1;
		#1;
		check(flags_out, 6'h00);
		op(`OP_ADD, 8'h7F, 8'h01);
		op(`OP_ADD, 8'hFF, 8'h01);
		op(`OP_ADD_CARRY, 8'h10, 8'h20);
		op(`OP_SUB, 8'h00, 8'h01);
		op(`OP_DIFF_BORROW, 8'h80, 8'h00);
		op(`OP_DIFF_IMM, 8'h80, 8'h01);
		op(`OP_DIFF_IMM_BR, 8'h05, 8'h05);
		op(`OP_WORD_PLUS, 8'hFF, 8'h01, 8'hFF);
		op(`OP_WORD_PLUS, 8'hFF, 8'h01, 8'h7F);
		op(`OP_WORD_MINUS, 8'h00, 8'h01, 8'h00);
		op(`OP_AND, 8'hF0, 8'h3C);
		op(`OP_CONJ_IMM, 8'h0F, 8'hF0);
		op(`OP_OR, 8'h80, 8'h01);
		op(`OP_DISJ_IMM, 8'h00, 8'h00);
		op(`OP_XOR, 8'h5A, 8'h5A);
		op(`OP_INVERT, 8'h00, 8'h00);
		op(`OP_ARITH_INV, 8'h80, 8'h00);
		op(`OP_ARITH_INV, 8'h01, 8'h00);
		io(`OP_IO_SET, 6'h1F, 3'h3, 1'b0, 1'b0, 8'hAD);
		io(`OP_IO_CLEAR, 6'h00, 3'h0, 1'b0, 1'b0, 8'hA4);
		io(`OP_IO_SET, 6'h20, 3'h1, 1'b0, 1'b1, 8'hA5);
		io(`OP_IO_CLEAR, 6'h3F, 3'h0, 1'b0, 1'b1, 8'hA5);
		io(`OP_SKIP_HIGH, 6'h1F, 3'h2, 1'b1, 1'b0, 8'hAD);
		io(`OP_SKIP_LOW, 6'h1F, 3'h1, 1'b1, 1'b0, 8'hAD);
		io(`OP_SKIP_HIGH, 6'h1F, 3'h1, 1'b0, 1'b0, 8'hAD);
		io(`OP_SKIP_LOW, 6'h25, 3'h0, 1'b0, 1'b1, 8'hA5);
		// a start held into the busy cycle is ignored
		@(posedge mclk_in);
		op_in <= `OP_WORD_PLUS;
		dst_in <= 8'h01;
		imm_in <= 8'h01;
		dst_high_in <= 8'h00;
		start_in <= 1'b1;
		@(posedge mclk_in);
		op_in <= `OP_ADD;
		@(posedge mclk_in);
		start_in <= 1'b0;
		#1;
		ef = {ef[5], 5'h00};
		check({done_out, busy_out}, 2'h2);
		check({result_high_out, result_out}, 16'h0002);
		check(flags_out, ef);
		@(posedge mclk_in);
		#1;
		check({done_out, busy_out, result_we_out}, 3'h0);
		// an unknown code only reports done
		run(`OP_NONE, 8'h12, 8'h34, 8'h00, 6'h00, 3'h0);
		check({result_we_out, io_we_out, io_range_err_out}, 3'h0);
		check({flags_out, result_out}, {ef, 8'h02});
		finish_test;
	end
endmodule // arith_logic_datapath_test
`default_nettype wire

// >>> sim/io_space_model.sv
// io register space seen by the datapath
`timescale 1ns/1ps
`default_nettype none
module io_space_model (
	input  wire       mclk_in,
	input  wire [5:0] io_addr_in,
	input  wire [7:0] io_wdata_in,
	input  wire [7:0] io_wmask_in,
	input  wire       io_we_in,
	output wire [7:0] io_data_out
);
	reg [7:0] mem [0:63];
	integer   i;
	initial for (i = 0; i < 64; i = i + 1) mem[i] = 8'hA5;
	assign io_data_out = mem[io_addr_in];
	// masked merge of a bit write
	always @(posedge mclk_in) begin
		if (io_we_in) mem[io_addr_in] <= (mem[io_addr_in] & ~io_wmask_in) | (io_wdata_in & io_wmask_in);
	end
endmodule // io_space_model
`default_nettype wire
